//--- rtl/decode_tail_map.svh
`ifndef DECODE_TAIL_MAP_SVH
`define DECODE_TAIL_MAP_SVH
// Functional notes
// RL1: opcode 97 copies accumulator into index in 2 cycles, flags untouched.
// RL2: opcode 9F copies index into accumulator in 2 cycles, flags untouched.
// RL3: byte test subtracts zero; 3D/4D/5D/6D/7D take 4/3/3/5/4 cycles.
// RL4: opcode 8F takes 2 cycles, halts clock, clears interrupt mask.
// RL5: bit-test-branch fetches direct address byte, then signed branch offset.
// RL6: word-offset indexed fetches offset high then low, adds index.
// RL7: full-address mode fetches address high byte then low byte.
// RL8: byte-offset indexed fetches one unsigned offset byte, adds index.
// RL9: blank opcodes are flagged illegal and not executed.

// ---------------------------------------------------------------
// opcodes
// ---------------------------------------------------------------
`define OPC_COPY_A2X    8'h97
`define OPC_COPY_X2A    8'h9F
`define OPC_TEST_DIR    8'h3D
`define OPC_TEST_ACC    8'h4D
`define OPC_TEST_IDX    8'h5D
`define OPC_TEST_IX1    8'h6D
`define OPC_TEST_IX0    8'h7D
`define OPC_WAIT        8'h8F

// ---------------------------------------------------------------
// cycle counts, opcode byte counted as cycle one
// ---------------------------------------------------------------
`define CYC_COPY        4'h2
`define CYC_TEST_DIR    4'h4
`define CYC_TEST_REG    4'h3
`define CYC_TEST_IX1    4'h5
`define CYC_TEST_IX0    4'h4
`define CYC_WAIT        4'h2

// ---------------------------------------------------------------
// defined rows per opcode column, bit n = low nibble n
// ---------------------------------------------------------------
`define LEGAL_COL_FULL  16'hFFFF
`define LEGAL_COL_RMW   16'hB7D9
`define LEGAL_COL_INHA  16'hB7DD
`define LEGAL_COL_CTL8  16'hC00B
`define LEGAL_COL_CTL9  16'hBF80
`define LEGAL_COL_IMM   16'h6F7F

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_BYTE        8'h00
`define RST_WORD        16'h0000
`define RST_READY       1'b1
`endif

//--- rtl/cpu_decode_pkg.sv
package cpu_decode_pkg;
   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_OPND  = 5'b00010,
      ST_MEMRD = 5'b00100,
      ST_FIN   = 5'b01000,
      ST_HALT  = 5'b10000
   } state_t;

   typedef enum logic [2:0] {
      AM_NONE  = 3'h0,
      AM_DIR   = 3'h1,
      AM_FULL  = 3'h2,
      AM_IDX0  = 3'h3,
      AM_IDX8  = 3'h4,
      AM_IDX16 = 3'h5,
      AM_BITBR = 3'h6
   } addr_mode_t;
endpackage : cpu_decode_pkg

//--- rtl/operand_if.sv
`timescale 1ns/1ps
interface operand_if;
   logic        clear;
   logic        strobe;
   logic [7:0]  data;
   logic [15:0] word;
   logic [1:0]  count;
   modport asm_side (input clear, input strobe, input data, output word, output count);
   modport ctl_side (output clear, output strobe, output data, input word, input count);
endinterface : operand_if

//--- rtl/operand_assembler.sv
`timescale 1ns/1ps
`include "decode_tail_map.svh"
module operand_assembler (
   // clock and reset
   input  wire logic   clk,
   input  wire logic   rst_n,
   // operand bytes
   operand_if.asm_side bus
);
   logic [15:0] word_ff;
   logic [1:0]  count_ff;

   assign bus.word  = word_ff;
   assign bus.count = count_ff;

   // first byte lands high once the second arrives
   always_ff @(posedge clk) begin
      if (!rst_n || bus.clear) begin
         word_ff  <= `RST_WORD;
         count_ff <= 2'h0;
      end else if (bus.strobe) begin
         word_ff  <= {word_ff[7:0], bus.data}; // RL6 RL7 RL5
         count_ff <= count_ff + 2'h1;
      end
   end
endmodule : operand_assembler

//--- rtl/cpu_opcode_decode_tail.sv
`timescale 1ns/1ps
`include "decode_tail_map.svh"
module cpu_opcode_decode_tail (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // instruction byte stream
   input  wire logic        fetchValid,
   input  wire logic [7:0]  fetchByte,
   output wire logic        fetchReady,
   // operand memory read
   output wire logic        memRd,
   output wire logic [15:0] memAddr,
   input  wire logic        memAck,
   input  wire logic [7:0]  memData,
   // register loads from the alu
   input  wire logic        accLoad,
   input  wire logic [7:0]  accIn,
   input  wire logic        idxLoad,
   input  wire logic [7:0]  idxIn,
   // wake from halt
   input  wire logic        wakeRequest,
   // core state and results
   output wire logic [7:0]  acc,
   output wire logic [7:0]  idx,
   output wire logic        instrDone,
   output wire logic        illegalOp,
   output wire logic        addrValid,
   output wire logic [15:0] effAddr,
   output wire logic [7:0]  branchOffset,
   output wire logic        flagWrite,
   output wire logic        negFlag,
   output wire logic        zeroFlag,
   output wire logic        intMaskClear,
   output wire logic        clockHalted
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   localparam logic [255:0] LEGAL_MAP = {
      `LEGAL_COL_FULL, `LEGAL_COL_FULL, `LEGAL_COL_FULL, `LEGAL_COL_FULL,
      `LEGAL_COL_FULL, `LEGAL_COL_IMM,  `LEGAL_COL_CTL9, `LEGAL_COL_CTL8,
      `LEGAL_COL_RMW,  `LEGAL_COL_RMW,  `LEGAL_COL_RMW,  `LEGAL_COL_INHA,
      `LEGAL_COL_RMW,  `LEGAL_COL_FULL, `LEGAL_COL_FULL, `LEGAL_COL_FULL};

   cpu_decode_pkg::state_t     st_ff;
   cpu_decode_pkg::state_t     nxt_st;
   cpu_decode_pkg::addr_mode_t mode_ff;
   cpu_decode_pkg::addr_mode_t curMode;
   logic [7:0]  opc_ff;
   logic [7:0]  acc_ff;
   logic [7:0]  idx_ff;
   logic [7:0]  testVal_ff;
   logic [3:0]  cnt_ff;
   logic        gotData_ff;
   logic        fetchReady_ff;
   logic        memRd_ff;
   logic [15:0] memAddr_ff;
   logic        done_ff;
   logic        illegal_ff;
   logic        addrValid_ff;
   logic [15:0] effAddr_ff;
   logic [7:0]  branch_ff;
   logic        flagWrite_ff;
   logic        neg_ff;
   logic        zero_ff;
   logic        maskClr_ff;
   logic        halted_ff;

   operand_if opb ();
   operand_assembler u_asm (.clk(clk), .rst_n(rst_n), .bus(opb));

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   wire        inIdle    = st_ff == cpu_decode_pkg::ST_IDLE;
   wire        accept    = inIdle && fetchValid && fetchReady_ff;
   wire        isLegal   = LEGAL_MAP[fetchByte];
   wire        start     = accept && isLegal;
   wire        badOp     = accept && !isLegal; // RL9
   wire [7:0]  curOp     = inIdle ? fetchByte : opc_ff;
   wire [3:0]  col       = curOp[7:4];
   wire        oneByte   = col == 4'h1 || col == 4'h2 || col == 4'h3 || col == 4'h6
                        || col == 4'hA || col == 4'hB || col == 4'hE;
   wire        twoBytes  = col == 4'h0 || col == 4'hC || col == 4'hD;
   wire [1:0]  needBytes = twoBytes ? 2'h2 : (oneByte ? 2'h1 : 2'h0);
   wire        isTestMem = curOp == `OPC_TEST_DIR || curOp == `OPC_TEST_IX1
                        || curOp == `OPC_TEST_IX0;
   wire        isTestReg = curOp == `OPC_TEST_ACC || curOp == `OPC_TEST_IDX;
   wire        isA2X     = curOp == `OPC_COPY_A2X;
   wire        isX2A     = curOp == `OPC_COPY_X2A;
   wire        isWait    = curOp == `OPC_WAIT;

   assign curMode = (col == 4'h0) ? cpu_decode_pkg::AM_BITBR :
                    (col == 4'h1 || col == 4'h3 || col == 4'hB) ? cpu_decode_pkg::AM_DIR :
                    (col == 4'hC) ? cpu_decode_pkg::AM_FULL :
                    (col == 4'hD) ? cpu_decode_pkg::AM_IDX16 :
                    (col == 4'h6 || col == 4'hE) ? cpu_decode_pkg::AM_IDX8 :
                    (col == 4'h7 || col == 4'hF) ? cpu_decode_pkg::AM_IDX0 :
                    cpu_decode_pkg::AM_NONE;

   // other opcodes carry no cycle figure here: they end once operands are in
   wire [3:0]  target = (isA2X || isX2A)           ? `CYC_COPY :
                        (curOp == `OPC_TEST_DIR)   ? `CYC_TEST_DIR :
                        isTestReg                  ? `CYC_TEST_REG :
                        (curOp == `OPC_TEST_IX1)   ? `CYC_TEST_IX1 :
                        (curOp == `OPC_TEST_IX0)   ? `CYC_TEST_IX0 :
                        isWait                     ? `CYC_WAIT : 4'h0; // RL1 RL2 RL3 RL4
   wire [3:0]  tgtLast = (target == 4'h0) ? 4'h0 : target - 4'h1;

   // ---------------------------------------------------------------
   // operand bytes and address forming
   // ---------------------------------------------------------------
   wire        byteTake = st_ff == cpu_decode_pkg::ST_OPND && fetchValid && fetchReady_ff;
   wire [1:0]  cntNext  = opb.count + 2'h1;
   wire        lastByte = byteTake && cntNext == needBytes;
   // bypass lets the read go out on the edge that takes the last byte
   wire [7:0]  lowByte  = byteTake ? fetchByte : opb.word[7:0];
   wire [15:0] twoByte  = byteTake ? {opb.word[7:0], fetchByte} : opb.word;
   wire [15:0] idxWide  = {8'h00, idx_ff};
   wire [15:0] addrDir  = {8'h00, lowByte};
   wire [15:0] addrBit  = {8'h00, twoByte[15:8]};                      // RL5
   wire [15:0] addrIdx8 = addrDir + idxWide;                           // RL8
   wire [15:0] addrIdx16 = twoByte + idxWide;                          // RL6
   wire [15:0] addrNow  =
      (curMode == cpu_decode_pkg::AM_BITBR) ? addrBit :
      (curMode == cpu_decode_pkg::AM_DIR)   ? addrDir :
      (curMode == cpu_decode_pkg::AM_FULL)  ? twoByte :                // RL7
      (curMode == cpu_decode_pkg::AM_IDX8)  ? addrIdx8 :
      (curMode == cpu_decode_pkg::AM_IDX16) ? addrIdx16 :
      (curMode == cpu_decode_pkg::AM_IDX0)  ? idxWide : `RST_WORD;

   assign opb.clear  = start;
   assign opb.strobe = byteTake;
   assign opb.data   = fetchByte;

   // ---------------------------------------------------------------
   // completion and test result
   // ---------------------------------------------------------------
   wire        inMem    = st_ff == cpu_decode_pkg::ST_MEMRD;
   wire        inFin    = st_ff == cpu_decode_pkg::ST_FIN;
   wire        dataOk   = inFin || gotData_ff || memAck;
   wire        finish   = (inFin || inMem) && cnt_ff >= tgtLast && dataOk;
   wire [7:0]  memByte  = gotData_ff ? testVal_ff : memData;
   wire [7:0]  testSrc  = (curOp == `OPC_TEST_ACC) ? acc_ff :
                          (curOp == `OPC_TEST_IDX) ? idx_ff : memByte;
   wire [7:0]  testDiff = testSrc - 8'h00;                             // RL3
   cpu_decode_pkg::state_t afterBytes;
   assign afterBytes = isTestMem ? cpu_decode_pkg::ST_MEMRD : cpu_decode_pkg::ST_FIN;

   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         cpu_decode_pkg::ST_IDLE: begin
            if (start) begin
               nxt_st = (needBytes != 2'h0) ? cpu_decode_pkg::ST_OPND : afterBytes;
            end
         end
         cpu_decode_pkg::ST_OPND: begin
            if (lastByte) begin
               nxt_st = afterBytes;
            end
         end
         cpu_decode_pkg::ST_MEMRD, cpu_decode_pkg::ST_FIN: begin
            if (finish) begin
               nxt_st = isWait ? cpu_decode_pkg::ST_HALT : cpu_decode_pkg::ST_IDLE; // RL4
            end
         end
         cpu_decode_pkg::ST_HALT: begin
            if (wakeRequest) begin
               nxt_st = cpu_decode_pkg::ST_IDLE;
            end
         end
         default: nxt_st = cpu_decode_pkg::ST_IDLE;
      endcase
   end

   wire        nxtReady = nxt_st == cpu_decode_pkg::ST_IDLE || nxt_st == cpu_decode_pkg::ST_OPND;
   wire        issueRd  = nxt_st == cpu_decode_pkg::ST_MEMRD && !inMem;
   wire        busyCnt  = !inIdle && st_ff != cpu_decode_pkg::ST_HALT && cnt_ff != 4'hF;

   // ---------------------------------------------------------------
   // sequencing
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff         <= cpu_decode_pkg::ST_IDLE;
         opc_ff        <= `RST_BYTE;
         cnt_ff        <= 4'h0;
         fetchReady_ff <= `RST_READY;
      end else begin
         st_ff         <= nxt_st;
         opc_ff        <= start ? fetchByte : opc_ff;
         cnt_ff        <= start ? 4'h1 : (busyCnt ? cnt_ff + 4'h1 : cnt_ff);
         fetchReady_ff <= nxtReady;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         memRd_ff   <= 1'b0;
         memAddr_ff <= `RST_WORD;
         gotData_ff <= 1'b0;
         testVal_ff <= `RST_BYTE;
      end else begin
         memRd_ff   <= issueRd;
         memAddr_ff <= issueRd ? addrNow : memAddr_ff;
         gotData_ff <= inMem && !finish && (gotData_ff || memAck);
         testVal_ff <= (inMem && memAck) ? memData : testVal_ff;
      end
   end

   // ---------------------------------------------------------------
   // results
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         done_ff      <= 1'b0;
         illegal_ff   <= 1'b0;
         addrValid_ff <= 1'b0;
         effAddr_ff   <= `RST_WORD;
         branch_ff    <= `RST_BYTE;
         mode_ff      <= cpu_decode_pkg::AM_NONE;
         flagWrite_ff <= 1'b0;
         neg_ff       <= 1'b0;
         zero_ff      <= 1'b0;
         maskClr_ff   <= 1'b0;
         halted_ff    <= 1'b0;
      end else begin
         done_ff      <= finish;
         illegal_ff   <= badOp;                                        // RL9
         addrValid_ff <= finish && curMode != cpu_decode_pkg::AM_NONE;
         effAddr_ff   <= finish ? addrNow : effAddr_ff;
         branch_ff    <= (finish && curMode == cpu_decode_pkg::AM_BITBR) ? opb.word[7:0] : branch_ff;
         mode_ff      <= finish ? curMode : mode_ff;
         flagWrite_ff <= finish && (isTestMem || isTestReg);           // RL3
         neg_ff       <= (finish && (isTestMem || isTestReg)) ? testDiff[7] : neg_ff;
         zero_ff      <= (finish && (isTestMem || isTestReg)) ? testDiff == 8'h00 : zero_ff;
         maskClr_ff   <= finish && isWait;                             // RL4
         halted_ff    <= nxt_st == cpu_decode_pkg::ST_HALT;            // RL4
      end
   end

   // copies win over alu loads; both never land in one cycle in practice
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         acc_ff <= `RST_BYTE;
         idx_ff <= `RST_BYTE;
      end else begin
         acc_ff <= (finish && isX2A) ? idx_ff : (accLoad ? accIn : acc_ff); // RL2
         idx_ff <= (finish && isA2X) ? acc_ff : (idxLoad ? idxIn : idx_ff); // RL1
      end
   end

   assign fetchReady   = fetchReady_ff;
   assign memRd        = memRd_ff;
   assign memAddr      = memAddr_ff;
   assign acc          = acc_ff;
   assign idx          = idx_ff;
   assign instrDone    = done_ff;
   assign illegalOp    = illegal_ff;
   assign addrValid    = addrValid_ff;
   assign effAddr      = effAddr_ff;
   assign branchOffset = branch_ff;
   assign flagWrite    = flagWrite_ff;
   assign negFlag      = neg_ff;
   assign zeroFlag     = zero_ff;
   assign intMaskClear = maskClr_ff;
   assign clockHalted  = halted_ff;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_copy_a2x;
      (start && fetchByte == `OPC_COPY_A2X && !accLoad)
         |-> ##2 (done_ff && !flagWrite_ff && idx_ff == $past(acc_ff, 2));
   endproperty
   a_copy_a2x: assert property (p_copy_a2x) else $error("acc to index copy wrong"); // RL1

   property p_copy_x2a;
      (start && fetchByte == `OPC_COPY_X2A && !idxLoad)
         |-> ##1 !done_ff ##1 (done_ff && !flagWrite_ff && acc_ff == $past(idx_ff, 2));
   endproperty
   a_copy_x2a: assert property (p_copy_x2a) else $error("index to acc copy wrong"); // RL2

   property p_test_acc;
      (start && fetchByte == `OPC_TEST_ACC && !accLoad)
         |-> ##3 (done_ff && flagWrite_ff && zero_ff == ($past(acc_ff, 3) == 8'h00));
   endproperty
   a_test_acc: assert property (p_test_acc) else $error("accumulator test wrong"); // RL3

   property p_wait_halt;
      (start && fetchByte == `OPC_WAIT) |-> ##2 (done_ff && intMaskClear) ##1 clockHalted;
   endproperty
   a_wait_halt: assert property (p_wait_halt) else $error("wait did not halt"); // RL4

   property p_bitbr_addr;
      (addrValid_ff && mode_ff == cpu_decode_pkg::AM_BITBR)
         |-> (effAddr_ff == {8'h00, opb.word[15:8]} && branch_ff == opb.word[7:0]);
   endproperty
   a_bitbr_addr: assert property (p_bitbr_addr) else $error("bit branch operands wrong"); // RL5

   property p_idx16_addr;
      (addrValid_ff && mode_ff == cpu_decode_pkg::AM_IDX16 && !$past(idxLoad))
         |-> effAddr_ff == opb.word + {8'h00, idx_ff};
   endproperty
   a_idx16_addr: assert property (p_idx16_addr) else $error("word offset address wrong"); // RL6

   property p_full_addr;
      (addrValid_ff && mode_ff == cpu_decode_pkg::AM_FULL) |-> effAddr_ff == opb.word;
   endproperty
   a_full_addr: assert property (p_full_addr) else $error("full address wrong"); // RL7

   property p_idx8_addr;
      (addrValid_ff && mode_ff == cpu_decode_pkg::AM_IDX8 && !$past(idxLoad))
         |-> effAddr_ff == {8'h00, opb.word[7:0]} + {8'h00, idx_ff};
   endproperty
   a_idx8_addr: assert property (p_idx8_addr) else $error("byte offset address wrong"); // RL8

   property p_illegal;
      badOp |=> (illegalOp && st_ff == cpu_decode_pkg::ST_IDLE && !done_ff);
   endproperty
   a_illegal: assert property (p_illegal) else $error("blank opcode not refused"); // RL9

   c_test_mem:  cover property (flagWrite_ff && opc_ff == `OPC_TEST_IX1);
   c_wait_wake: cover property (clockHalted ##1 !clockHalted);
   c_illegal:   cover property (illegalOp);
endmodule : cpu_opcode_decode_tail

//--- dv/cpu_opcode_decode_tail_tb.sv
`timescale 1ns/1ps
module cpu_opcode_decode_tail_tb;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic        clk;
   logic        rst_n;
   logic        fetchValid;
   logic [7:0]  fetchByte;
   logic        accLoad;
   logic [7:0]  accIn;
   logic        idxLoad;
   logic [7:0]  idxIn;
   logic        wakeRequest;
   logic [7:0]  rdValue;
   logic [15:0] rdAddr;
   wire logic   fetchReady;
   wire logic   memRd;
   wire logic   memAck;
   wire logic   instrDone;
   wire logic   illegalOp;
   wire logic   addrValid;
   wire logic   flagWrite;
   wire logic   negFlag;
   wire logic   zeroFlag;
   wire logic   intMaskClear;
   wire logic   clockHalted;
   wire logic [15:0] memAddr;
   wire logic [15:0] effAddr;
   wire logic [7:0]  memData;
   wire logic [7:0]  acc;
   wire logic [7:0]  idx;
   wire logic [7:0]  branchOffset;
   int          failCount;
   int          checksDone;
   int          doneCyc;
   int          illCyc;

   // ------------------------------------------------------------
   // memory answer
   // ------------------------------------------------------------
   // same-cycle ack keeps the documented counts; bus inverted when idle
   assign memAck  = memRd;
   assign memData = memRd ? rdValue : ~rdValue;

   cpu_opcode_decode_tail i_dut (
      .clk(clk), .rst_n(rst_n),
      .fetchValid(fetchValid), .fetchByte(fetchByte), .fetchReady(fetchReady),
      .memRd(memRd), .memAddr(memAddr), .memAck(memAck), .memData(memData),
      .accLoad(accLoad), .accIn(accIn), .idxLoad(idxLoad), .idxIn(idxIn),
      .wakeRequest(wakeRequest), .acc(acc), .idx(idx), .instrDone(instrDone),
      .illegalOp(illegalOp), .addrValid(addrValid), .effAddr(effAddr),
      .branchOffset(branchOffset), .flagWrite(flagWrite), .negFlag(negFlag),
      .zeroFlag(zeroFlag), .intMaskClear(intMaskClear), .clockHalted(clockHalted)
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checksDone++;
      if (got !== exp) begin
         failCount++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic completeRun();
      $display("checks %0d mismatches %0d", checksDone, failCount);
      if (failCount == 0 && checksDone > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : completeRun

   task automatic setRegs(input logic [7:0] a, input logic [7:0] x);
      @(posedge clk);
      accLoad <= 1'b1;
      accIn   <= a;
      idxLoad <= 1'b1;
      idxIn   <= x;
      @(posedge clk);
      accLoad <= 1'b0;
      idxLoad <= 1'b0;
   endtask : setRegs

   // cycle index counts edges from the one that takes the opcode
   task automatic send(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                       input int n, input int maxCyc);
      int k;
      int cyc;
      k = 0;
      cyc = 0;
      doneCyc = -1;
      illCyc = -1;
      @(posedge clk);
      fetchValid <= 1'b1;
      fetchByte  <= b0;
      while (cyc < maxCyc && doneCyc < 0) begin
         @(posedge clk);
         cyc++;
         if (fetchValid === 1'b1 && fetchReady === 1'b1) begin
            k++;
            fetchByte <= (k == 1) ? b1 : b2;
            if (k >= n) fetchValid <= 1'b0;
         end
         #1;
         if (memRd === 1'b1) rdAddr = memAddr;
         if (illegalOp === 1'b1 && illCyc < 0) illCyc = cyc;
         if (instrDone === 1'b1) doneCyc = cyc;
      end
   endtask : send

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic testRegisterForms();
      setRegs(8'h80, 8'h00);
      send(8'h4D, 8'h00, 8'h00, 1, 10);
      chk("acc test cycles", 16'h0003, 16'(doneCyc));
      chk("acc test flags", 16'h0006, {13'h0, flagWrite, negFlag, zeroFlag});
      send(8'h5D, 8'h00, 8'h00, 1, 10);
      chk("idx test cycles", 16'h0003, 16'(doneCyc));
      chk("idx test flags", 16'h0005, {13'h0, flagWrite, negFlag, zeroFlag});
   endtask : testRegisterForms

   task automatic testMemoryForms();
      setRegs(8'h00, 8'h10);
      rdValue = 8'h00;
      send(8'h3D, 8'h44, 8'h00, 2, 12);
      chk("direct test cycles", 16'h0004, 16'(doneCyc));
      chk("direct read address", 16'h0044, rdAddr);
      chk("direct test flags", 16'h0005, {13'h0, flagWrite, negFlag, zeroFlag});
      rdValue = 8'hFF;
      send(8'h6D, 8'hF8, 8'h00, 2, 12);
      chk("offset test cycles", 16'h0005, 16'(doneCyc));
      chk("offset read address", 16'h0108, rdAddr);
      chk("offset eff address", 16'h0108, effAddr);
      chk("offset test flags", 16'h0006, {13'h0, flagWrite, negFlag, zeroFlag});
      // negative result leaves negFlag set and zeroFlag clear, so the copies must keep them
      rdValue = 8'h80;
      send(8'h7D, 8'h00, 8'h00, 1, 12);
      chk("zero offset cycles", 16'h0004, 16'(doneCyc));
      chk("zero offset address", 16'h0010, rdAddr);
      chk("zero offset flags", 16'h0006, {13'h0, flagWrite, negFlag, zeroFlag});
   endtask : testMemoryForms

   task automatic testCopies();
      setRegs(8'h3C, 8'h00);
      send(8'h97, 8'h00, 8'h00, 1, 10);
      chk("copy to index cycles", 16'h0002, 16'(doneCyc));
      chk("copy to index value", 16'h003C, {8'h00, idx});
      chk("copy to index flags", 16'h0002, {13'h0, flagWrite, negFlag, zeroFlag});
      setRegs(8'h00, 8'hA5);
      send(8'h9F, 8'h00, 8'h00, 1, 10);
      chk("copy to acc cycles", 16'h0002, 16'(doneCyc));
      chk("copy to acc value", 16'h00A5, {8'h00, acc});
      chk("copy to acc flags", 16'h0002, {13'h0, flagWrite, negFlag, zeroFlag});
   endtask : testCopies

   task automatic testOperandOrder();
      setRegs(8'h00, 8'hF0);
      send(8'hC6, 8'h12, 8'h34, 3, 20);
      chk("full address", 16'h1234, effAddr);
      chk("full address valid", 16'h0001, {15'h0, addrValid});
      send(8'hD6, 8'hFF, 8'h20, 3, 20);
      chk("word offset address", 16'h0010, effAddr);
      send(8'hE6, 8'h20, 8'h00, 2, 20);
      chk("byte offset address", 16'h0110, effAddr);
      send(8'h07, 8'h55, 8'hFE, 3, 20);
      chk("bit branch address", 16'h0055, effAddr);
      chk("bit branch offset", 16'h00FE, {8'h00, branchOffset});
   endtask : testOperandOrder

   task automatic testWait();
      send(8'h8F, 8'h00, 8'h00, 1, 10);
      chk("wait cycles", 16'h0002, 16'(doneCyc));
      chk("wait halt state", 16'h0006, {13'h0, intMaskClear, clockHalted, fetchReady});
      repeat (3) @(posedge clk);
      #1;
      chk("halt holds", 16'h0002, {14'h0, clockHalted, fetchReady});
      @(posedge clk);
      wakeRequest <= 1'b1;
      @(posedge clk);
      wakeRequest <= 1'b0;
      #1;
      chk("wake release", 16'h0001, {14'h0, clockHalted, fetchReady});
   endtask : testWait

   task automatic testIllegal();
      // blank cells spread over several columns of the map
      logic [7:0] ops [5] = '{8'h31, 8'h45, 8'h82, 8'h9E, 8'hAC};
      foreach (ops[i]) begin
         send(ops[i], 8'h00, 8'h00, 1, 4);
         chk("illegal pulse cycle", 16'h0001, 16'(illCyc));
         chk("illegal no done", 16'hFFFF, 16'(doneCyc));
         chk("illegal stays idle", 16'h0001, {15'h0, fetchReady});
      end
   endtask : testIllegal

   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      fetchValid = 1'b0;
      fetchByte = 8'h00;
      accLoad = 1'b0;
      accIn = 8'h00;
      idxLoad = 1'b0;
      idxIn = 8'h00;
      wakeRequest = 1'b0;
      rdValue = 8'h00;
      rdAddr = 16'h0000;
      failCount = 0;
      checksDone = 0;
      repeat (7) @(posedge clk);
      #1;
      chk("reset outputs", 16'h0001, {12'h0, instrDone, clockHalted, flagWrite, fetchReady});
      chk("reset registers", 16'h0000, {acc, idx});
      @(posedge clk);
      rst_n <= 1'b1;
      testRegisterForms();
      testMemoryForms();
      testCopies();
      testOperandOrder();
      testWait();
      testIllegal();
      completeRun();
   end

   // whole run needs about a hundred cycles; fifty times that is ample
   initial begin
      repeat (5000) @(posedge clk);
      failCount++;
      $display("wrong value run length expected finish seen timeout");
      completeRun();
   end
endmodule : cpu_opcode_decode_tail_tb
